//--- pkg/ppr_pkg.sv
// Constants and rate table for the primary port rate and clock setup block
package ppr_pkg;
   // ****************************************
   // Bus and map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [7:0] CFG_INDEX = 8'h32;
   localparam logic [ADDR_W-1:0] CFG_ADDR = {2'b00, CFG_INDEX, 2'b00};
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h100;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ****************************************
   // Fields
   // ****************************************
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 2;
   localparam int TOL_BIT = 1;
   localparam int MANUAL_BIT = 0;
   localparam int ST_OK_BIT = 8;
   localparam int ST_RSV_BIT = 9;
   localparam int ST_AUTO_BIT = 10;
   localparam int ST_MAN_BIT = 11;
   localparam int ST_TOL_BIT = 12;
   localparam logic [5:0] AUTO_CODE = 6'h00;
   localparam logic [5:0] LAST_RATE_CODE = 6'h26;
   localparam int RATE_W = 20;
   localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
   localparam logic [31:0] TOL_NARROW_PCT = 32'h0000_0001;
   localparam logic [31:0] TOL_WIDE_PCT = 32'h0000_0005;
   // ****************************************
   // Rate table: {nominal, lowest, highest}
   // ****************************************
   function automatic logic [59:0] rate_entry(input logic [5:0] code);
      case (code)
         6'd1: rate_entry = {20'd768000, 20'd670320, 20'd791040};
         6'd2: rate_entry = {20'd614400, 20'd536256, 20'd632832};
         6'd3: rate_entry = {20'd512000, 20'd446880, 20'd527360};
         6'd4: rate_entry = {20'd438857, 20'd383040, 20'd452022};
         6'd5: rate_entry = {20'd384000, 20'd335160, 20'd395520};
         6'd6: rate_entry = {20'd341333, 20'd297920, 20'd351573};
         6'd7: rate_entry = {20'd307200, 20'd268128, 20'd316416};
         6'd8: rate_entry = {20'd256000, 20'd223440, 20'd263680};
         6'd9: rate_entry = {20'd219429, 20'd191520, 20'd226011};
         6'd10: rate_entry = {20'd192000, 20'd167580, 20'd197760};
         6'd11: rate_entry = {20'd170667, 20'd148960, 20'd175786};
         6'd12: rate_entry = {20'd153600, 20'd134064, 20'd158208};
         6'd13: rate_entry = {20'd128000, 20'd111720, 20'd131840};
         6'd14: rate_entry = {20'd109714, 20'd95760, 20'd113005};
         6'd15: rate_entry = {20'd96000, 20'd83790, 20'd98880};
         6'd16: rate_entry = {20'd85333, 20'd74480, 20'd87893};
         6'd17: rate_entry = {20'd76800, 20'd67032, 20'd79104};
         6'd18: rate_entry = {20'd64000, 20'd55860, 20'd65920};
         6'd19: rate_entry = {20'd54857, 20'd47880, 20'd56502};
         6'd20: rate_entry = {20'd48000, 20'd41895, 20'd49440};
         6'd21: rate_entry = {20'd42667, 20'd37240, 20'd43946};
         6'd22: rate_entry = {20'd38400, 20'd33516, 20'd39552};
         6'd23: rate_entry = {20'd32000, 20'd27930, 20'd32960};
         6'd24: rate_entry = {20'd27429, 20'd23940, 20'd28251};
         6'd25: rate_entry = {20'd24000, 20'd20947, 20'd24720};
         6'd26: rate_entry = {20'd21333, 20'd18620, 20'd21973};
         6'd27: rate_entry = {20'd19200, 20'd16758, 20'd19776};
         6'd28: rate_entry = {20'd16000, 20'd13965, 20'd16480};
         6'd29: rate_entry = {20'd13714, 20'd11970, 20'd14125};
         6'd30: rate_entry = {20'd12000, 20'd10473, 20'd12360};
         6'd31: rate_entry = {20'd10667, 20'd9310, 20'd10986};
         6'd32: rate_entry = {20'd9600, 20'd8379, 20'd9888};
         6'd33: rate_entry = {20'd8000, 20'd6982, 20'd8240};
         6'd34: rate_entry = {20'd6857, 20'd5985, 20'd7062};
         6'd35: rate_entry = {20'd6000, 20'd5236, 20'd6180};
         6'd36: rate_entry = {20'd5333, 20'd4655, 20'd5493};
         6'd37: rate_entry = {20'd4800, 20'd4189, 20'd4944};
         6'd38: rate_entry = {20'd4000, 20'd4189, 20'd4944};
         default: rate_entry = 60'h0;
      endcase
   endfunction
endpackage

//--- rtl/ppr_clock_setup.sv
// Primary port rate selector, tolerance and clock mode register with rate check
`timescale 1ns/10ps
module ppr_clock_setup
   import ppr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Measured rate from the same-clock rate counter
   input wire logic [RATE_W-1:0] detected_rate_in,
   // Clock setup outputs
   output logic [5:0] primary_port_rate_select_out,
   output logic auto_rate_tolerance_wide_out,
   output logic manual_clock_out,
   output logic auto_detect_out,
   output logic [5:0] effective_code_out,
   output logic [RATE_W-1:0] nominal_rate_out,
   output logic [RATE_W-1:0] rate_min_out,
   output logic [RATE_W-1:0] rate_max_out,
   output logic rate_ok_out,
   output logic code_reserved_out
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] cfg_reg;
   logic awready_reg;
   logic wready_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic auto_reg;
   logic [5:0] eff_code_reg;
   logic [RATE_W-1:0] nom_reg;
   logic [RATE_W-1:0] min_reg;
   logic [RATE_W-1:0] max_reg;
   logic ok_reg;
   logic rsvd_reg;

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic commit;
   logic [ADDR_W-1:0] wr_word;
   logic [ADDR_W-1:0] rd_word;
   logic [31:0] status_word;

   assign aw_hs = s_axi_awvalid_in && awready_reg;
   assign w_hs = s_axi_wvalid_in && wready_reg;
   assign ar_hs = s_axi_arvalid_in && arready_reg;
   // Address and data may come in either order; the write waits for both
   assign commit = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_word = {aw_addr_reg[ADDR_W-1:2], 2'b00};
   assign rd_word = {s_axi_araddr_in[ADDR_W-1:2], 2'b00};

   // ****************************************
   // Write channels
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         awready_reg <= 1'b0;
      end else if (aw_hs) begin
         awready_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_hs) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr_in;
      end else if (commit) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wready_reg <= 1'b0;
      end else if (w_hs) begin
         wready_reg <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (w_hs) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata_in;
         w_strb_reg <= s_axi_wstrb_in;
      end else if (commit) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (commit) begin
         bvalid_reg <= 1'b1;
         // Status is read-only, so a write there is refused like a hole
         bresp_reg <= (wr_word == CFG_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ****************************************
   // Configuration register
   // ****************************************
   // Only byte lane 0 carries the 8-bit register
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_reg <= CFG_RESET;
      end else if (commit && wr_word == CFG_ADDR && w_strb_reg[0]) begin
         cfg_reg <= w_data_reg[7:0];
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[5:0] = eff_code_reg;
      status_word[ST_OK_BIT] = ok_reg;
      status_word[ST_RSV_BIT] = rsvd_reg;
      status_word[ST_AUTO_BIT] = auto_reg;
      status_word[ST_MAN_BIT] = cfg_reg[MANUAL_BIT];
      status_word[ST_TOL_BIT] = cfg_reg[TOL_BIT];
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         arready_reg <= 1'b0;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (ar_hs) begin
         rvalid_reg <= 1'b1;
         if (rd_word == CFG_ADDR) begin
            rresp_reg <= RESP_OKAY;
            rdata_reg <= {24'h00_0000, cfg_reg};
         end else if (rd_word == STATUS_ADDR) begin
            rresp_reg <= RESP_OKAY;
            rdata_reg <= status_word;
         end else begin
            rresp_reg <= RESP_SLVERR;
            rdata_reg <= 32'h0000_0000;
         end
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ****************************************
   // Rate decode and automatic detection
   // ****************************************
   logic [5:0] sel;
   logic auto_now;
   logic rsvd_now;
   logic [31:0] tol_pct;
   logic [63:1] hit;
   logic [5:0] found_code;
   logic [5:0] eff_code;
   logic [59:0] eff_entry;
   logic ok_now;

   assign sel = cfg_reg[SEL_MSB:SEL_LSB];
   assign auto_now = (sel == AUTO_CODE);
   assign rsvd_now = (sel > LAST_RATE_CODE);
   // Narrow window unless the tolerance bit widens it
   assign tol_pct = cfg_reg[TOL_BIT] ? TOL_WIDE_PCT : TOL_NARROW_PCT;

   // One comparator per standard rate; distance scaled to avoid a divider
   for (genvar i = 1; i < 64; i++) begin : g_rate
      logic [59:0] ent;
      logic [31:0] nom_w;
      logic [31:0] det_w;
      logic [31:0] diff_w;
      assign ent = rate_entry(6'(i));
      assign nom_w = {12'h000, ent[59:40]};
      assign det_w = {12'h000, detected_rate_in};
      assign diff_w = (det_w > nom_w) ? (det_w - nom_w) : (nom_w - det_w);
      assign hit[i] = (6'(i) <= LAST_RATE_CODE) && (nom_w != 32'h0000_0000)
         && (diff_w * PCT_SCALE <= nom_w * tol_pct);
   end

   // Lowest matching code wins when windows overlap
   always_comb begin
      found_code = AUTO_CODE;
      for (int k = 63; k >= 1; k--) begin
         if (hit[k]) begin
            found_code = 6'(k);
         end
      end
   end

   assign eff_code = auto_now ? found_code : sel;
   assign eff_entry = rate_entry(eff_code);

   always_comb begin
      if (auto_now) begin
         ok_now = (found_code != AUTO_CODE);
      end else if (rsvd_now) begin
         ok_now = 1'b0;
      end else begin
         ok_now = (detected_rate_in >= eff_entry[39:20])
            && (detected_rate_in <= eff_entry[19:0]);
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         auto_reg <= 1'b1;
         eff_code_reg <= AUTO_CODE;
         nom_reg <= '0;
         min_reg <= '0;
         max_reg <= '0;
         ok_reg <= 1'b0;
         rsvd_reg <= 1'b0;
      end else begin
         auto_reg <= auto_now;
         eff_code_reg <= eff_code;
         nom_reg <= eff_entry[59:40];
         min_reg <= eff_entry[39:20];
         max_reg <= eff_entry[19:0];
         ok_reg <= ok_now;
         rsvd_reg <= rsvd_now;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready_out = awready_reg;
   assign s_axi_wready_out = wready_reg;
   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out = bresp_reg;
   assign s_axi_arready_out = arready_reg;
   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rresp_out = rresp_reg;
   assign s_axi_rdata_out = rdata_reg;
   assign primary_port_rate_select_out = cfg_reg[SEL_MSB:SEL_LSB];
   assign auto_rate_tolerance_wide_out = cfg_reg[TOL_BIT];
   // Manual mode only flags the clock tree; dividers live elsewhere
   assign manual_clock_out = cfg_reg[MANUAL_BIT];
   assign auto_detect_out = auto_reg;
   assign effective_code_out = eff_code_reg;
   assign nominal_rate_out = nom_reg;
   assign rate_min_out = min_reg;
   assign rate_max_out = max_reg;
   assign rate_ok_out = ok_reg;
   assign code_reserved_out = rsvd_reg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_cfg_write;
      commit && (wr_word == CFG_ADDR) && w_strb_reg[0];
   endsequence

   sequence s_sel_code(logic [5:0] c);
      primary_port_rate_select_out == c;
   endsequence

   a_select_write: assert property (
      s_cfg_write |=> primary_port_rate_select_out == $past(w_data_reg[7:2]))
      else $error("Rate selector did not take written value");
   a_auto_zero: assert property (
      s_sel_code(6'h00) |=> auto_detect_out && effective_code_out == $past(found_code))
      else $error("Selector zero did not select auto detection");
   a_code_768k: assert property (
      s_sel_code(6'h01) |=> nominal_rate_out == 20'd768000
         && rate_min_out == 20'd670320 && rate_max_out == 20'd791040)
      else $error("Code 1 decode wrong");
   a_code_96k: assert property (
      s_sel_code(6'h0F) |=> nominal_rate_out == 20'd96000
         && rate_min_out == 20'd83790 && rate_max_out == 20'd98880)
      else $error("Code 15 decode wrong");
   a_code_48k: assert property (
      s_sel_code(6'h14) |=> nominal_rate_out == 20'd48000
         && rate_min_out == 20'd41895 && rate_max_out == 20'd49440)
      else $error("Code 20 decode wrong");
   a_code_16k: assert property (
      s_sel_code(6'h1C) |=> nominal_rate_out == 20'd16000
         && rate_min_out == 20'd13965 && rate_max_out == 20'd16480)
      else $error("Code 28 decode wrong");
   a_code_8k: assert property (
      s_sel_code(6'h21) |=> nominal_rate_out == 20'd8000
         && rate_min_out == 20'd6982 && rate_max_out == 20'd8240)
      else $error("Code 33 decode wrong");
   a_code_4k8: assert property (
      s_sel_code(6'h25) |=> nominal_rate_out == 20'd4800
         && rate_min_out == 20'd4189 && rate_max_out == 20'd4944)
      else $error("Code 37 decode wrong");
   a_narrow_reject: assert property (
      (s_sel_code(6'h00) and (!cfg_reg[TOL_BIT] && detected_rate_in == 20'd50000))
      |=> !rate_ok_out)
      else $error("Narrow tolerance accepted a 4 percent offset");
   a_wide_accept: assert property (
      (s_sel_code(6'h00) and (cfg_reg[TOL_BIT] && detected_rate_in == 20'd50000))
      |=> rate_ok_out && effective_code_out == 6'h14)
      else $error("Wide tolerance rejected a 4 percent offset");
   a_auto_clock: assert property (
      s_cfg_write ##0 !w_data_reg[0] |=> !manual_clock_out [*2])
      else $error("Clearing manual bit did not restore auto clocking");
   a_reserved_code: assert property (
      (primary_port_rate_select_out > LAST_RATE_CODE)
      |=> code_reserved_out && !rate_ok_out && nominal_rate_out == '0)
      else $error("Reserved code not flagged");

endmodule // ppr_clock_setup

//--- verif/ppr_clock_setup_tb.sv
// Self-checking bench for the primary port rate and clock setup register
`timescale 1ns/10ps
module ppr_clock_setup_tb;
   import ppr_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic sys_clk_in;
   logic rst_in;
   logic [ADDR_W-1:0] awaddr;
   logic [ADDR_W-1:0] araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic [RATE_W-1:0] det;
   logic [5:0] sel_out;
   logic [5:0] eff_out;
   logic tol_out, man_out, auto_out, ok_out, rsv_out;
   logic [RATE_W-1:0] nom_out;
   logic [RATE_W-1:0] min_out;
   logic [RATE_W-1:0] max_out;
   int num_errors = 0;
   int comparisons = 0;
   int tab_code[6] = '{1, 15, 20, 28, 33, 37};
   int tab_nom[6] = '{768000, 96000, 48000, 16000, 8000, 4800};
   int tab_min[6] = '{670320, 83790, 41895, 13965, 6982, 4189};
   int tab_max[6] = '{791040, 98880, 49440, 16480, 8240, 4944};

   ppr_clock_setup dut_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .detected_rate_in(det),
      .primary_port_rate_select_out(sel_out), .auto_rate_tolerance_wide_out(tol_out),
      .manual_clock_out(man_out), .auto_detect_out(auto_out), .effective_code_out(eff_out),
      .nominal_rate_out(nom_out), .rate_min_out(min_out), .rate_max_out(max_out),
      .rate_ok_out(ok_out), .code_reserved_out(rsv_out)
   );

   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic complete_run();
      $display("Comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask

   // Bounded wait: a slave that never answers ends the run as a failure
   task automatic timed_out(input bit done);
      if (!done) begin
         num_errors++;
         $display("[ERR] bus answer timed out");
         complete_run();
      end
   endtask

   task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] resp);
      int n;
      bit done;
      @(posedge sys_clk_in);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      done = 0;
      resp = 2'b11;
      while (!done && n < 60) begin
         @(posedge sys_clk_in);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      timed_out(done);
   endtask

   task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                           output logic [1:0] resp);
      int n;
      bit done;
      @(posedge sys_clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      done = 0;
      while (!done && n < 60) begin
         @(posedge sys_clk_in);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
      timed_out(done);
   endtask

   // Derived outputs lag the register by one clock, so settle before looking
   task automatic set_cfg(input logic [7:0] v);
      logic [1:0] r;
      bus_write(CFG_ADDR, {24'h0000_00, v}, 4'h1, r);
      check("cfg write resp", r, RESP_OKAY);
      tick(3);
   endtask

   function automatic logic in_tol(input int d, input int nom, input int pct);
      int diff;
      diff = (d > nom) ? d - nom : nom - d;
      return (diff * 100 <= nom * pct);
   endfunction

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] rv;
      logic [31:0] rd;
      logic [1:0] resp;
      int rdet;
      rst_in = 1'b1;
      awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; det = '0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      void'($urandom(32'hc1d4af43));
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      tick(2);
      check("reset select", sel_out, 6'h00);
      check("reset auto", auto_out, 1'b1);
      check("reset manual", man_out, 1'b0);
      bus_read(CFG_ADDR, rd, resp);
      check("reset readback", rd, 32'h0000_0000);
      // Documented rate codes, at both edges of the allowed range
      for (int i = 0; i < 6; i++) begin
         det <= tab_min[i];
         set_cfg({tab_code[i][5:0], 2'b00});
         check("select", sel_out, tab_code[i]);
         check("eff code", eff_out, tab_code[i]);
         check("nominal", nom_out, tab_nom[i]);
         check("min", min_out, tab_min[i]);
         check("max", max_out, tab_max[i]);
         check("ok at min", ok_out, 1'b1);
         check("not auto", auto_out, 1'b0);
         det <= tab_max[i] + 1;
         tick(3);
         check("ok above max", ok_out, 1'b0);
         det <= tab_min[i] - 1;
         tick(3);
         check("ok below min", ok_out, 1'b0);
      end
      // Automatic detection at the edges of both tolerances
      for (int t = 0; t < 2; t++) begin
         for (int d = 0; d < 5; d++) begin
            rdet = (d == 0) ? 48480 : (d == 1) ? 48481 : (d == 2) ? 50400 :
               (d == 3) ? 50401 : 50000;
            det <= rdet;
            set_cfg({6'h00, t[0], 1'b0});
            check("auto flag", auto_out, 1'b1);
            check("tol out", tol_out, t[0]);
            check("auto ok", ok_out, in_tol(rdet, 48000, t ? 5 : 1));
            check("auto code", eff_out, in_tol(rdet, 48000, t ? 5 : 1) ? 20 : 0);
         end
      end
      // Manual clock setup and status reflection
      set_cfg(8'h53);
      check("manual", man_out, 1'b1);
      bus_read(CFG_ADDR, rd, resp);
      check("manual readback", rd, 32'h0000_0053);
      bus_read(STATUS_ADDR, rd, resp);
      check("status manual", rd[ST_MAN_BIT], 1'b1);
      check("status tol", rd[ST_TOL_BIT], 1'b1);
      // Reserved code 63 and the last entry, code 38
      for (int c = 38; c < 64; c += 25) begin
         det <= 20'h0_1194;
         set_cfg({c[5:0], 2'b00});
         check("reserved", rsv_out, c > 38);
         if (c > 38) check("reserved ok", ok_out, 1'b0);
      end
      // Disabled byte lane, unmapped and read-only places
      set_cfg(8'h50);
      bus_write(CFG_ADDR, 32'h0000_00ff, 4'he, resp);
      check("no strobe resp", resp, RESP_OKAY);
      bus_read(CFG_ADDR, rd, resp);
      check("no strobe keep", rd, 32'h0000_0050);
      bus_write(12'h004, 32'h0000_0001, 4'hf, resp);
      check("unmapped wr", resp, RESP_SLVERR);
      bus_write(STATUS_ADDR, 32'h0000_0001, 4'hf, resp);
      check("status wr", resp, RESP_SLVERR);
      bus_read(12'h004, rd, resp);
      check("unmapped rd", resp, RESP_SLVERR);
      check("unmapped data", rd, 32'h0000_0000);
      bus_read(CFG_ADDR, rd, resp);
      check("still kept", rd, 32'h0000_0050);
      // Random configurations with upper data bits that must be ignored
      for (int k = 0; k < 24; k++) begin
         rv = $urandom();
         rdet = $urandom_range(800000, 2000);
         det <= rdet[RATE_W-1:0];
         bus_write(CFG_ADDR, rv, 4'hf, resp);
         tick(3);
         check("rnd select", sel_out, rv[7:2]);
         check("rnd tol", tol_out, rv[1]);
         check("rnd manual", man_out, rv[0]);
         check("rnd auto", auto_out, rv[7:2] == 6'h00);
         check("rnd reserved", rsv_out, rv[7:2] > 6'h26);
         bus_read(CFG_ADDR, rd, resp);
         check("rnd readback", rd, {24'h0000_00, rv[7:0]});
      end
      // A second reset in mid-run returns every field to zero
      rst_in <= 1'b1;
      tick(2);
      rst_in <= 1'b0;
      tick(2);
      bus_read(CFG_ADDR, rd, resp);
      check("rereset readback", rd, 32'h0000_0000);
      complete_run();
   end
endmodule // ppr_clock_setup_tb
